// ### hdl/cfs_regs.svh
// register offsets, field positions, reset values and timing counts for the converter fault sequencer
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH

// ------------------------------------------------------------
// register word addresses (byte address = 4 * index)
// ------------------------------------------------------------
`define CFS_ADDR_CTRL      2'h0
`define CFS_ADDR_STATUS    2'h1
`define CFS_ADDR_FAULTS    2'h2
`define CFS_ADDR_TIMING    2'h3

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CFS_CTRL_ENABLE    0
`define CFS_CTRL_RESET     32'h0000_0000

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define CFS_ST_SWITCHING   0
`define CFS_ST_FAULT_IND   1
`define CFS_ST_LATCH       2
`define CFS_ST_TRIM        3
`define CFS_ST_CLIMIT      4
`define CFS_ST_STATE_LSB   8

// ------------------------------------------------------------
// fault bits, write one to clear; input and temperature bits also clear in CFS_OFF once their condition is gone
// ------------------------------------------------------------
`define CFS_F_IN_LOW       0
`define CFS_F_IN_HIGH      1
`define CFS_F_OUT_LOW      2
`define CFS_F_TEMP         3
`define CFS_F_OUT_HIGH     4

// ------------------------------------------------------------
// timing, as time and as cycles of the 10 MHz clock
// ------------------------------------------------------------
`define CFS_CLK_HZ         10000000
`define CFS_CLIMIT_US      1000
`define CFS_CLIMIT_CYC     ((`CFS_CLIMIT_US * (`CFS_CLK_HZ / 1000000)))
`define CFS_IN_FILT_CYC    16
`define CFS_OV_FILT_CYC    16
`define CFS_FAULT_CYC      1000
`define CFS_INIT_CYC       200
`define CFS_TON_CYC        100

`endif

// ### hdl/cfs_pkg.sv
// types shared by the converter fault sequencer
package cfs_pkg;

  typedef enum logic [2:0] {
    CFS_OFF,
    CFS_INIT,
    CFS_TON,
    CFS_RUN,
    CFS_HOLD,
    CFS_WAIT_CLEAR
  } cfs_state_t;

  typedef struct packed {
    logic input_low_lockout;   // input below falling lockout level
    logic input_above_rise;    // input above rising lockout level
    logic input_high_lockout;  // input above rising overvoltage level
    logic input_below_ov_fall; // input below falling overvoltage level
    logic output_low_fault;    // sensed output below undervoltage level
    logic output_high;         // sensed output above overvoltage level
    logic temp_high;           // internal temperature above limit
    logic over_current;        // output current above limit threshold
    logic input_init_loss;     // input below initialization level
  } cfs_sense_t;

  typedef struct packed {
    logic in_low;
    logic in_high;
    logic out_low;
    logic temp;
    logic out_high;
  } cfs_faults_t;

endpackage : cfs_pkg

// ### hdl/cfs_sequencer.sv
// converter fault supervision, restart sequencing and avalon-mm register slave
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "cfs_regs.svh"

// Summary of operation
// RULE1: when stopped, ignore enable until input rises above rising lockout level.
// RULE2: while running, input below falling lockout registers fault, stops switching.
// RULE3: input dips shorter than the filter time are ignored, no fault.
// RULE4: after input-low fault, wait for input above rising level, restart if enabled.
// RULE5: input above rising overvoltage level registers fault and stops switching.
// RULE6: after overvoltage fault, wait input below falling level, restart if enabled.
// RULE7: fast overvoltage halts switching at once; short events resume without fault.
// RULE8: overvoltage longer than its filter time is a fault, running or not.
// RULE9: while switching, output below undervoltage level registers fault, stops at once.
// RULE10: after output-low fault, keep powertrain off for the fault hold time.
// RULE11: output-low recovery, if enabled, waits init then turn-on delay, then soft start.
// RULE12: overtemperature registers fault, stops at once, holds off at least hold time.
// RULE13: after hold, wait for temperature clear, then init and turn-on delays.
// RULE14: output above overvoltage level while switching disables the powertrain.
// RULE15: output overvoltage is latched; no restart while the latch is set.
// RULE16: latch clears only on enable low or input below initialization level.
// RULE17: current-limit action is held off a fixed interval after overcurrent.
// RULE18: sustained current limit alone raises no fault and no shutdown.
// RULE19: current limit pulling output under undervoltage level takes output-low path.
// RULE20: fault indication active whenever powertrain stopped, inactive enabled and clean.
// RULE21: latched trim mode never changes on fault recovery or disable.
// RULE22: filter, hold, init and turn-on intervals are clock counters, configurable.
// RULE23: with several faults, every condition must clear before any restart.
module cfs_sequencer #(
  parameter int IN_FILT_CYC = `CFS_IN_FILT_CYC,
  parameter int OV_FILT_CYC = `CFS_OV_FILT_CYC,
  parameter int FAULT_CYC   = `CFS_FAULT_CYC,
  parameter int INIT_CYC    = `CFS_INIT_CYC,
  parameter int TON_CYC     = `CFS_TON_CYC,
  parameter int CLIMIT_CYC  = `CFS_CLIMIT_CYC,
  parameter int CW          = 16
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire cfs_pkg::cfs_sense_t sense,
  input  wire logic               enable_pin,
  input  wire logic               trim_request,
  input  wire logic [1:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  output logic                    powertrain_on,
  output logic                    fault_indication,
  output logic                    current_limit_active,
  output logic                    trim_active
);
  import cfs_pkg::*;

  initial begin
    if (IN_FILT_CYC < 1 || OV_FILT_CYC < 1 || FAULT_CYC < 1 || INIT_CYC < 1 || TON_CYC < 1 ||
        CLIMIT_CYC < 1 || FAULT_CYC >= (1 << CW) || INIT_CYC >= (1 << CW) ||
        TON_CYC >= (1 << CW) || CLIMIT_CYC >= (1 << CW) || IN_FILT_CYC >= (1 << CW) ||
        OV_FILT_CYC >= (1 << CW))
      $error("cfs_sequencer: timing counts out of range");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  cfs_state_t  state;
  cfs_faults_t faults;
  logic [CW-1:0] tmr;
  logic [CW-1:0] in_low_cnt;
  logic [CW-1:0] ov_cnt;
  logic [CW-1:0] cl_cnt;
  logic          sw_enable;
  logic          output_high_latch;
  logic          trim_taken;
  logic          enabled;
  logic          in_low_ev;
  logic          ov_ev;
  logic          any_block;
  logic          stop_now;
  logic          clr_hit;
  logic [4:0]    clr_mask;
  logic          acc;
  logic          wr_done;

  assign enabled = enable_pin & sw_enable;
  assign acc     = (avs_read | avs_write) & avs_waitrequest;
  // writes land on the edge that completes the transfer, not the accepting one
  assign wr_done = avs_write & ~avs_waitrequest;

  // ------------------------------------------------------------
  // input filters
  // ------------------------------------------------------------
  // a dip must last the filter time before it counts
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      in_low_cnt <= '0;
    end else if (sense.input_low_lockout && state == CFS_RUN) begin
      if (in_low_cnt != CW'(IN_FILT_CYC))
        in_low_cnt <= in_low_cnt + 1'b1; // RULE3 RULE22
    end else begin
      in_low_cnt <= '0;
    end
  end

  // counts in every state, so overvoltage is seen while stopped too
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_cnt <= '0;
    end else if (sense.input_high_lockout) begin
      if (ov_cnt != CW'(OV_FILT_CYC))
        ov_cnt <= ov_cnt + 1'b1; // RULE8 RULE22
    end else begin
      ov_cnt <= '0;
    end
  end

  assign in_low_ev = (in_low_cnt == CW'(IN_FILT_CYC)); // RULE2
  assign ov_ev     = (ov_cnt == CW'(OV_FILT_CYC)); // RULE5 RULE8

  // ------------------------------------------------------------
  // fault flags and output overvoltage latch
  // ------------------------------------------------------------
  // anything still present blocks the restart, plus the latch
  assign any_block = (faults.in_low & ~sense.input_above_rise) |          // RULE4
                     (faults.in_high & ~sense.input_below_ov_fall) |      // RULE6
                     (faults.temp & sense.temp_high) |                    // RULE13
                     output_high_latch |                                  // RULE15
                     ~sense.input_above_rise | sense.input_high_lockout;  // RULE23

  assign stop_now = in_low_ev | ov_ev | (sense.output_low_fault & powertrain_on) | // RULE9 RULE19
                    sense.temp_high | (sense.output_high & powertrain_on);         // RULE12 RULE14

  assign clr_hit  = wr_done && avs_address == `CFS_ADDR_FAULTS && avs_byteenable[0];
  assign clr_mask = clr_hit ? avs_writedata[4:0] : 5'h00;

  // set wins over a software clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      faults <= '0;
    end else begin
      faults.in_low   <= (faults.in_low & ~clr_mask[`CFS_F_IN_LOW] &
                          ~(state == CFS_OFF && sense.input_above_rise)) | in_low_ev; // RULE2 RULE4
      faults.in_high  <= (faults.in_high & ~clr_mask[`CFS_F_IN_HIGH] &
                          ~(state == CFS_OFF && sense.input_below_ov_fall)) | ov_ev; // RULE5 RULE6
      faults.out_low  <= (faults.out_low & ~clr_mask[`CFS_F_OUT_LOW]) |
                         (sense.output_low_fault & powertrain_on); // RULE9 RULE19
      faults.temp     <= (faults.temp & ~clr_mask[`CFS_F_TEMP] &
                          ~(state == CFS_OFF && !sense.temp_high)) | sense.temp_high; // RULE12
      faults.out_high <= (faults.out_high & ~clr_mask[`CFS_F_OUT_HIGH]) |
                         (sense.output_high & powertrain_on); // RULE14
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      output_high_latch <= 1'b0;
    end else if (sense.output_high && powertrain_on) begin
      output_high_latch <= 1'b1; // RULE15
    end else if (!enable_pin || sense.input_init_loss) begin
      output_high_latch <= 1'b0; // RULE16
    end
  end

  // ------------------------------------------------------------
  // restart sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CFS_OFF;
      tmr   <= '0;
    end else begin
      case (state)
        CFS_OFF: begin
          // enable is ignored until input clears the rising lockout
          if (enabled && !any_block) begin // RULE1 RULE23
            state <= CFS_INIT;
            tmr   <= '0;
          end
        end
        CFS_INIT: begin
          if (stop_now || !enabled || any_block) begin
            state <= CFS_OFF;
          end else if (tmr == CW'(INIT_CYC - 1)) begin
            state <= CFS_TON; // RULE11 RULE22
            tmr   <= '0;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        CFS_TON: begin
          if (stop_now || !enabled || any_block) begin
            state <= CFS_OFF;
          end else if (tmr == CW'(TON_CYC - 1)) begin
            state <= CFS_RUN; // RULE11 RULE22
            tmr   <= '0;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        CFS_RUN: begin
          if ((sense.output_low_fault && powertrain_on) || sense.temp_high) begin
            state <= CFS_HOLD; // RULE10 RULE12
            tmr   <= '0;
          end else if (stop_now || !enabled) begin
            state <= CFS_OFF; // RULE2 RULE5 RULE14
          end
        end
        CFS_HOLD: begin
          if (tmr == CW'(FAULT_CYC - 1)) begin
            state <= CFS_WAIT_CLEAR; // RULE10 RULE12 RULE22
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        CFS_WAIT_CLEAR: begin
          if (!sense.temp_high) begin
            state <= CFS_OFF; // RULE13
          end
        end
        default: begin
          state <= CFS_OFF;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // powertrain gate and fault indication
  // ------------------------------------------------------------
  // controller-level overvoltage masks switching before the filter expires
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      powertrain_on <= 1'b0;
    end else begin
      powertrain_on <= (state == CFS_RUN) && enabled && !stop_now &&
                       !sense.input_high_lockout && !output_high_latch; // RULE7 RULE9 RULE12 RULE15
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_indication <= 1'b1;
    end else begin
      fault_indication <= !((state == CFS_RUN) && enabled && !stop_now &&
                            !sense.input_high_lockout && !output_high_latch); // RULE20
    end
  end

  // ------------------------------------------------------------
  // current-limit hold-off
  // ------------------------------------------------------------
  // only a flag toward the analog loop; never a fault by itself
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cl_cnt               <= '0;
      current_limit_active <= 1'b0;
    end else if (sense.over_current && powertrain_on) begin
      if (cl_cnt != CW'(CLIMIT_CYC))
        cl_cnt <= cl_cnt + 1'b1; // RULE17
      current_limit_active <= (cl_cnt == CW'(CLIMIT_CYC)); // RULE17 RULE18
    end else begin
      cl_cnt               <= '0;
      current_limit_active <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // trim mode, caught once input first rises
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_taken  <= 1'b0;
      trim_active <= 1'b0;
    end else if (sense.input_init_loss) begin
      trim_taken <= 1'b0;
    end else if (!trim_taken && sense.input_above_rise) begin
      trim_taken  <= 1'b1; // RULE21
      trim_active <= trim_request;
    end
  end

  // ------------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_enable <= 1'(`CFS_CTRL_RESET);
    end else if (wr_done && avs_address == `CFS_ADDR_CTRL && avs_byteenable[0]) begin
      sw_enable <= avs_writedata[`CFS_CTRL_ENABLE];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      case (avs_address)
        `CFS_ADDR_CTRL:   avs_readdata <= {31'h0, sw_enable};
        `CFS_ADDR_STATUS: avs_readdata <= {21'h0, state, 3'h0, current_limit_active, trim_active,
                                           output_high_latch, fault_indication, powertrain_on};
        `CFS_ADDR_FAULTS: avs_readdata <= {27'h0, faults.out_high, faults.temp, faults.out_low,
                                           faults.in_high, faults.in_low};
        `CFS_ADDR_TIMING: avs_readdata <= 32'(FAULT_CYC);
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end else begin
      avs_readdata <= 32'h0000_0000;
    end
  end

endmodule : cfs_sequencer

// ### test/cfs_sequencer_props.sv
// port-level assertions for the converter fault sequencer
`timescale 1ns/10ps
module cfs_sequencer_props #(
  parameter int IN_FILT_CYC = 16,
  parameter int FAULT_CYC   = 1000,
  parameter int INIT_CYC    = 200,
  parameter int TON_CYC     = 100,
  parameter int CLIMIT_CYC  = 10000
) (
  input wire logic                mclk,
  input wire logic                sys_rst,
  input wire cfs_pkg::cfs_sense_t sense,
  input wire logic                enable_pin,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest,
  input wire logic                powertrain_on,
  input wire logic                fault_indication,
  input wire logic                current_limit_active,
  input wire logic                trim_active
);
  import cfs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----
  // helpers
  // ----
  logic [15:0] off_n, oc_n, low_n;
  logic        hold_s, ov_s, lat, rise_s;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      off_n <= '0;
      oc_n <= '0;
      low_n <= '0;
    end else begin
      off_n <= powertrain_on ? '0 : off_n + 16'h1;
      oc_n <= (sense.over_current && powertrain_on) ? oc_n + 16'h1 : '0;
      low_n <= sense.input_low_lockout ? low_n + 16'h1 : '0;
    end
  end
  // flags stay set across the off stretch, so the restart edge still sees them
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_s <= 1'b0;
      ov_s <= 1'b0;
      lat <= 1'b0;
      rise_s <= 1'b0;
    end else begin
      hold_s <= (powertrain_on && (sense.output_low_fault || sense.temp_high)) || (hold_s && !powertrain_on);
      ov_s <= sense.input_high_lockout || (ov_s && !powertrain_on);
      lat <= (powertrain_on && sense.output_high) || (lat && enable_pin && !sense.input_init_loss);
      rise_s <= !sense.input_init_loss && (rise_s || sense.input_above_rise);
    end
  end
  // ----
  // properties
  // ----
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_stop;
    ##[1:2] !powertrain_on;
  endsequence
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ans) else $error("bus answer");
  chk_fault_stop: assert property (powertrain_on && (sense.output_low_fault || sense.temp_high ||
    sense.output_high || sense.input_high_lockout) |-> s_stop) else $error("no stop on fault");
  chk_enable_off: assert property (!enable_pin [*3] |-> !powertrain_on && fault_indication) else $error("enable");
  chk_run_clean: assert property (powertrain_on && $past(powertrain_on) |-> !fault_indication) else $error("fault ind");
  chk_climit_run: assert property (powertrain_on && enable_pin && (9'(sense) & 9'h1fd) == 9'h0a0 |=> powertrain_on)
    else $error("dropped while clean");
  chk_in_low: assert property (low_n >= 16'(IN_FILT_CYC + 3) |-> !powertrain_on) else $error("input low");
  chk_climit_hold: assert property ($rose(current_limit_active) |-> oc_n >= 16'(CLIMIT_CYC)) else $error("climit");
  chk_start_delay: assert property ($rose(powertrain_on) && !ov_s |-> off_n >= 16'(INIT_CYC + TON_CYC))
    else $error("start early");
  chk_hold_time: assert property ($rose(powertrain_on) && hold_s |-> off_n >= 16'(FAULT_CYC + INIT_CYC + TON_CYC))
    else $error("hold short");
  chk_latch_hold: assert property (lat |-> !$rose(powertrain_on)) else $error("restart while latched");
  chk_trim_kept: assert property (rise_s && $past(rise_s, 2) |-> $stable(trim_active)) else $error("trim moved");
endmodule : cfs_sequencer_props

bind cfs_sequencer cfs_sequencer_props #(.IN_FILT_CYC(IN_FILT_CYC), .FAULT_CYC(FAULT_CYC), .INIT_CYC(INIT_CYC),
  .TON_CYC(TON_CYC), .CLIMIT_CYC(CLIMIT_CYC)) i_props (.mclk(mclk), .sys_rst(sys_rst), .sense(sense),
  .enable_pin(enable_pin), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .powertrain_on(powertrain_on), .fault_indication(fault_indication),
  .current_limit_active(current_limit_active), .trim_active(trim_active));

// ### test/cfs_host.sv
// host model: drives enable and counts fault indications
`timescale 1ns/10ps
module cfs_host (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic want_en,
  input  wire logic fault_indication,
  output logic      enable_pin,
  output int        fault_events
);
  logic fi_q;
  // enable lags the request by one edge, like a slow host
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_pin <= 1'b0;
      fi_q <= 1'b1;
      fault_events <= 0;
    end else begin
      enable_pin <= want_en;
      fi_q <= fault_indication;
      if (fault_indication && !fi_q)
        fault_events <= fault_events + 1;
    end
  end
endmodule : cfs_host

// ### test/tb_top.sv
// self-checking bench for the converter fault sequencer
`timescale 1ns/10ps
`include "cfs_regs.svh"
module tb_top;
  import cfs_pkg::*;
  localparam int FC = 10, IC = 5, TC = 5, CC = 20, LONG = FC + IC + TC + 30;
  localparam logic [8:0] CLN = 9'h0a0, LOW = 9'h120, OV = 9'h0c0, OLF = 9'h0b2, OH = 9'h0a8, TMP = 9'h0a4;
  logic       mclk, sys_rst, want_en, enable_pin, trim_request, trim_exp;
  logic       avs_read, avs_write, avs_waitrequest, powertrain_on, fault_indication;
  logic       current_limit_active, trim_active;
  logic [1:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, seed;
  cfs_sense_t sense;
  int         failures, num_checks, cyc, fev0, fault_events, len;
  cfs_sequencer #(.FAULT_CYC(FC), .INIT_CYC(IC), .TON_CYC(TC), .CLIMIT_CYC(CC)) i_dut (.mclk(mclk),
    .sys_rst(sys_rst), .sense(sense), .enable_pin(enable_pin), .trim_request(trim_request),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .powertrain_on(powertrain_on), .fault_indication(fault_indication),
    .current_limit_active(current_limit_active), .trim_active(trim_active));
  cfs_host i_host (.mclk(mclk), .sys_rst(sys_rst), .want_en(want_en), .fault_indication(fault_indication),
    .enable_pin(enable_pin), .fault_events(fault_events));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] exp_f(input int idx);
    return 32'h1 << idx;
  endfunction : exp_f
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // waits on waitrequest, never on a fixed count
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk1(n < 50, 1'b1);
  endtask : bus
  task automatic setsn(input logic [8:0] v);
    @(posedge mclk);
    sense <= cfs_sense_t'(v);
  endtask : setsn
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask : waitc
  task automatic expect_pt(input logic v, input int max);
    int n;
    for (n = 0; n < max && powertrain_on !== v; n++)
      @(posedge mclk);
    chk1(powertrain_on, v);
  endtask : expect_pt
  // ----
  // clock, timeout, sequence
  // ----
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    sys_rst = 1'b1; want_en = 1'b0; trim_request = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 2'h0; avs_writedata = 32'h0; avs_byteenable = 4'h1; sense = cfs_sense_t'(9'h020);
    failures = 0; num_checks = 0; cyc = 0; seed = 32'hace539e3;
    waitc(4);
    sys_rst <= 1'b0;
    seed = lfsr(seed);
    trim_request <= seed[0];
    trim_exp = seed[0];
    chk1(fault_indication, 1'b1);
    bus(1'b1, `CFS_ADDR_TIMING, 32'hffff);
    bus(1'b0, `CFS_ADDR_TIMING, 32'h0);
    chk32(rd, 32'(FC));
    bus(1'b1, `CFS_ADDR_CTRL, 32'h1);
    want_en <= 1'b1;
    waitc(40);
    chk1(powertrain_on, 1'b0);
    setsn(CLN);
    expect_pt(1'b1, LONG);
    chk1(fault_indication, 1'b0);
    chk1(trim_active, trim_exp);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      len = (i == 0) ? 15 : 1 + int'(seed[3:0] % 4'hf);
      trim_request <= seed[5];
      setsn(LOW);
      waitc(len - 1);
      setsn(CLN);
      waitc(3);
      chk1(powertrain_on, 1'b1);
    end
    setsn(OV);
    waitc(2);
    chk1(powertrain_on, 1'b0);
    setsn(CLN);
    expect_pt(1'b1, 10);
    bus(1'b0, `CFS_ADDR_FAULTS, 32'h0);
    chk32(rd, 32'h0);
    setsn(LOW);
    waitc(30);
    chk1(powertrain_on, 1'b0);
    bus(1'b0, `CFS_ADDR_FAULTS, 32'h0);
    chk32(rd, exp_f(0));
    setsn(CLN);
    expect_pt(1'b1, LONG);
    bus(1'b1, `CFS_ADDR_FAULTS, 32'h1f);
    setsn(9'h0a2);
    waitc(CC - 5);
    chk1(current_limit_active, 1'b0);
    waitc(20);
    chk1(current_limit_active, 1'b1);
    waitc(50);
    chk1(powertrain_on, 1'b1);
    fev0 = fault_events;
    setsn(OLF);
    expect_pt(1'b0, 3);
    setsn(CLN);
    waitc(FC);
    chk1(powertrain_on, 1'b0);
    expect_pt(1'b1, LONG);
    bus(1'b0, `CFS_ADDR_FAULTS, 32'h0);
    chk32(rd & exp_f(2), exp_f(2));
    chk32(32'(fault_events), 32'(fev0 + 1));
    setsn(TMP);
    expect_pt(1'b0, 3);
    waitc(LONG);
    chk1(powertrain_on, 1'b0);
    setsn(CLN);
    expect_pt(1'b1, LONG);
    trim_request <= !trim_exp;
    setsn(OH);
    expect_pt(1'b0, 3);
    setsn(CLN);
    waitc(60);
    chk1(powertrain_on, 1'b0);
    want_en <= 1'b0;
    waitc(5);
    want_en <= 1'b1;
    expect_pt(1'b1, LONG);
    chk1(trim_active, trim_exp);
    setsn(OV);
    waitc(40);
    bus(1'b0, `CFS_ADDR_FAULTS, 32'h0);
    chk32(rd & exp_f(1), exp_f(1));
    setsn(CLN);
    expect_pt(1'b1, LONG);
    setsn(OV | TMP);
    expect_pt(1'b0, 3);
    waitc(FC + 10);
    setsn(OV);
    waitc(LONG);
    chk1(powertrain_on, 1'b0);
    setsn(CLN);
    expect_pt(1'b1, LONG);
    setsn(OH);
    expect_pt(1'b0, 3);
    setsn(9'h001);
    seed = lfsr(seed);
    trim_request <= seed[0];
    trim_exp = seed[0];
    waitc(5);
    setsn(CLN);
    expect_pt(1'b1, LONG);
    chk1(trim_active, trim_exp);
    want_en <= 1'b0;
    waitc(5);
    bus(1'b0, `CFS_ADDR_STATUS, 32'h0);
    chk32(rd & 32'h3, 32'h2);
    end_of_test();
  end
endmodule : tb_top
